// File: shared/bsd_defs.svh
// constants for the bit-skip, jump and increment decode core
`ifndef BSD_DEFS_SVH
`define BSD_DEFS_SVH

// ==========================================================
// opcode prefixes
`define BSD_OP_SKIP_CLR 4'hB
`define BSD_OP_SKIP_SET 4'hA
`define BSD_OP_INC 6'h0A
`define BSD_OP_JUMP_FIRST 8'hEF
`define BSD_OP_JUMP_SECOND 4'hF
`define BSD_TW_MOVE 4'hC
`define BSD_TW_CALL 7'h76
`define BSD_TW_LOADFSR 8'hEE
`define BSD_NOP_WORD 16'h0000

// ==========================================================
// field positions
`define BSD_BIT_HI 11
`define BSD_BIT_LO 9
`define BSD_DEST_BIT 9
`define BSD_BANK_BIT 8
`define BSD_FILE_HI 7
`define BSD_FILE_LO 0
`define BSD_JUMP_HI_MSB 11

// ==========================================================
// addressing
`define BSD_IDX_LIMIT 8'h5F
`define BSD_ACC_SPLIT 8'h60
`define BSD_ACC_LO_BANK 4'h0
`define BSD_ACC_HI_BANK 4'hF

// ==========================================================
// flag limits
`define BSD_BYTE_MAX 8'hFF
`define BSD_POS_MAX 8'h7F
`define BSD_NIB_MAX 4'hF
`define BSD_ONE 8'h01

// ==========================================================
// phases, reset values and timing
`define BSD_Q1 2'h0
`define BSD_Q2 2'h1
`define BSD_Q3 2'h2
`define BSD_Q4 2'h3
`define BSD_PHASE_STEP 2'h1
`define BSD_PC_RESET 21'h0_0000
`define BSD_PC_STEP 21'h0_0002
`define BSD_W_RESET 8'h00
`define BSD_CLK_NS 5
`define BSD_PHASES_PER_CYCLE 4

`endif

// File: shared/bsd_pkg.sv
// types for the bit-skip, jump and increment decode core
package bsd_pkg;

	typedef struct packed {
		logic [11:0] addr;
		logic [7:0] wdata;
		logic we;
	} bsd_file_req_t;

	typedef struct packed {
		logic n;
		logic ov;
		logic z;
		logic dc;
		logic c;
	} bsd_status_t;

	typedef enum logic [2:0] {
		cls_other,
		cls_skip_clr,
		cls_skip_set,
		cls_jump,
		cls_inc
	} bsd_class_t;

	typedef enum logic [1:0] {
		st_exec,
		st_nop_one,
		st_nop_two
	} bsd_state_t;

endpackage : bsd_pkg

// File: core/bsd_core.sv
// decode and execute core for bit skips, absolute jump and file increment
`timescale 1ns/100ps
`include "bsd_defs.svh"

module bsd_core (
	input wire logic clock,
	input wire logic rst_n,
	output logic [20:0] prog_addr,
	input wire logic [15:0] prog_data,
	output bsd_pkg::bsd_file_req_t file_req,
	input wire logic [7:0] file_rd_data,
	input wire logic [3:0] bank_select_register,
	input wire logic [11:0] index_base,
	input wire logic ext_set_en,
	output logic [7:0] w_reg,
	output bsd_pkg::bsd_status_t status,
	output logic [1:0] phase
);
	import bsd_pkg::*;

	// ==========================================================
	// state
	logic [20:0] pc;
	logic [15:0] ir;
	logic [7:0] operand;
	bsd_state_t state;
	bsd_class_t cls;
	logic [2:0] bit_sel;
	logic [7:0] file_sel;
	logic bank_bit;
	logic dest_bit;
	logic bit_val;
	logic do_skip;
	logic next_two_word;
	logic [11:0] next_addr;
	logic [8:0] inc_sum;
	logic [7:0] inc_result;
	bsd_status_t next_status;
	logic [20:0] jump_target;
	// one flop per request field; we and wdata share one process, addr has its own
	logic [11:0] req_addr;
	logic [7:0] req_wdata;
	logic req_we;

	assign prog_addr = pc;
	assign file_req = '{addr: req_addr, wdata: req_wdata, we: req_we};

	// ==========================================================
	// two-word detection on the word just fetched
	function automatic logic is_two_word(input logic [15:0] word);
		is_two_word = (word[15:12] == `BSD_TW_MOVE)
			|| (word[15:9] == `BSD_TW_CALL)
			|| (word[15:8] == `BSD_TW_LOADFSR)
			|| (word[15:8] == `BSD_OP_JUMP_FIRST);
	endfunction : is_two_word

	// ==========================================================
	// decode
	// field widths
	assign bit_sel = ir[`BSD_BIT_HI:`BSD_BIT_LO];
	assign file_sel = ir[`BSD_FILE_HI:`BSD_FILE_LO];
	assign bank_bit = ir[`BSD_BANK_BIT];
	assign dest_bit = ir[`BSD_DEST_BIT];

	// words discarded by a nop state decode as nothing
	always_comb begin
		cls = cls_other;
		if (state == st_exec) begin
			if (ir[15:12] == `BSD_OP_SKIP_CLR) begin
				cls = cls_skip_clr;
			end else if (ir[15:12] == `BSD_OP_SKIP_SET) begin
				cls = cls_skip_set;
			end else if (ir[15:10] == `BSD_OP_INC) begin
				cls = cls_inc;
			end else if (ir[15:8] == `BSD_OP_JUMP_FIRST) begin
				cls = cls_jump;
			end
		end
	end

	always_comb begin
		if (!bank_bit && ext_set_en && file_sel <= `BSD_IDX_LIMIT) begin
			next_addr = 12'(index_base + {4'h0, file_sel});
		end else if (!bank_bit) begin
			next_addr = (file_sel < `BSD_ACC_SPLIT) ? {`BSD_ACC_LO_BANK, file_sel}
				: {`BSD_ACC_HI_BANK, file_sel};
		end else begin
			next_addr = {bank_select_register, file_sel};
		end
	end

	// ==========================================================
	// execute datapath
	assign bit_val = operand[bit_sel];
	assign do_skip = (cls == cls_skip_clr && !bit_val) || (cls == cls_skip_set && bit_val);
	assign next_two_word = is_two_word(prog_data);

	assign inc_sum = {1'b0, operand} + {1'b0, `BSD_ONE};
	assign inc_result = inc_sum[7:0];

	always_comb begin
		next_status.c = inc_sum[8];
		next_status.dc = (operand[3:0] == `BSD_NIB_MAX);
		next_status.n = inc_result[7];
		next_status.ov = (operand == `BSD_POS_MAX);
		next_status.z = (inc_result == 8'h00);
	end

	// pc bits 20..1 from both words
	assign jump_target = {prog_data[`BSD_JUMP_HI_MSB:0], file_sel, 1'b0};

	// ==========================================================
	// phase divider: one clock per phase, four per cycle
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			phase <= `BSD_Q1;
		end else begin
			phase <= 2'(phase + `BSD_PHASE_STEP);
		end
	end

	// ==========================================================
	// q1: address for the read
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_addr <= 12'h000;
		end else if (phase == `BSD_Q1 && cls != cls_other && cls != cls_jump) begin
			req_addr <= next_addr;
		end
	end

	// q2: operand read
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			operand <= 8'h00;
		end else if (phase == `BSD_Q2) begin
			operand <= file_rd_data;
		end
	end

	// ==========================================================
	// q3: process; the write strobe covers q4 only
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			req_we <= 1'b0;
			req_wdata <= 8'h00;
		end else if (phase == `BSD_Q3 && cls == cls_inc) begin
			// dest bit 1 writes the file
			req_we <= dest_bit;
			req_wdata <= inc_result;
		end else begin
			req_we <= 1'b0;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			w_reg <= `BSD_W_RESET;
		end else if (phase == `BSD_Q3 && cls == cls_inc && !dest_bit) begin
			// dest bit 0 goes to working
			w_reg <= inc_result;
		end
	end

	// bit tests never reach this, so their flags stay put
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			status <= '0;
		end else if (phase == `BSD_Q3 && cls == cls_inc) begin
			status <= next_status;
		end
	end

	// ==========================================================
	// q4: fetch, program counter and discard tracking
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pc <= `BSD_PC_RESET;
			ir <= `BSD_NOP_WORD;
		end else if (phase == `BSD_Q4) begin
			ir <= prog_data;
			if (cls == cls_jump) begin
				pc <= jump_target;
			end else begin
				pc <= 21'(pc + `BSD_PC_STEP);
			end
		end
	end

	// skipped words are still fetched, just never decoded
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state <= st_exec;
		end else if (phase == `BSD_Q4) begin
			case (state)
				st_exec: begin
					if (do_skip && next_two_word) begin
						state <= st_nop_two;
					end else if (do_skip || cls == cls_jump) begin
						state <= st_nop_one;
					end else begin
						state <= st_exec;
					end
				end
				st_nop_two: begin
					state <= st_nop_one;
				end
				st_nop_one: begin
					state <= st_exec;
				end
				default: begin
					state <= st_exec;
				end
			endcase
		end
	end

	// ==========================================================
	// checks
	chk_clear_skip: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && cls == cls_skip_clr && !bit_val) |=> state != st_exec)
		else $error("skip on clear bit not taken");

	chk_set_skip: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && cls == cls_skip_set && bit_val) |=> state != st_exec)
		else $error("skip on set bit not taken");

	chk_bit_flags_kept: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q3 && (cls == cls_skip_clr || cls == cls_skip_set))
		|=> $stable(status) && !file_req.we)
		else $error("bit test touched flags or file");

	chk_skip_one_nop: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && do_skip && !next_two_word)
		|=> (state == st_nop_one && cls == cls_other)[*4] ##1 state == st_exec)
		else $error("single skip not one nop cycle");

	chk_skip_two_nop: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && do_skip && next_two_word)
		|=> state == st_nop_two ##4 state == st_nop_one ##4 state == st_exec)
		else $error("two-word skip not two nop cycles");

	chk_no_skip_one: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && (cls == cls_skip_clr || cls == cls_skip_set) && !do_skip)
		|=> state == st_exec)
		else $error("bit test without skip stalled");

	chk_banked_addr: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q1 && (cls == cls_inc || cls == cls_skip_set) && bank_bit)
		|=> file_req.addr == {$past(bank_select_register), $past(ir[7:0])})
		else $error("banked address wrong");

	chk_indexed_addr: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q1 && cls == cls_skip_clr && !bank_bit && ext_set_en
		&& file_sel <= `BSD_IDX_LIMIT)
		|=> file_req.addr == 12'($past(index_base) + {4'h0, $past(file_sel)}))
		else $error("indexed address wrong");

	chk_jump_target: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && cls == cls_jump) |=> pc == $past(jump_target) && pc[0] == 1'b0)
		else $error("jump did not load target");

	chk_jump_idle: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q4 && cls == cls_jump)
		|=> (cls == cls_other && !file_req.we)[*4] ##1 state == st_exec)
		else $error("jump second cycle not idle");

	chk_inc_file: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q3 && cls == cls_inc && dest_bit)
		|=> file_req.we && file_req.wdata == 8'($past(operand) + `BSD_ONE) ##1 !file_req.we)
		else $error("increment write wrong");

	chk_inc_working: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q3 && cls == cls_inc && !dest_bit)
		|=> !file_req.we && w_reg == 8'($past(operand) + `BSD_ONE))
		else $error("increment to working wrong");

	chk_inc_flags: assert property (@(posedge clock) disable iff (!rst_n)
		(phase == `BSD_Q3 && cls == cls_inc && operand == `BSD_BYTE_MAX)
		|=> status.z && status.c && status.dc && !status.n)
		else $error("increment flags wrong at wrap");

endmodule : bsd_core

// File: test/bsd_mem_model.sv
// program memory and data file model facing the decode core
`timescale 1ns/100ps

module bsd_mem_model (
	input wire logic clock,
	input wire logic [20:0] prog_addr,
	output logic [15:0] prog_data,
	input wire bsd_pkg::bsd_file_req_t file_req,
	output logic [7:0] file_rd_data
);
	import bsd_pkg::*;
	// aliased program store, so far jumps still land on real words
	logic [15:0] prog [256];
	logic [7:0] data_mem [4096];
	assign prog_data = prog[prog_addr[8:1]];
	assign file_rd_data = data_mem[file_req.addr];
	always @(posedge clock) begin
		if (file_req.we)
			data_mem[file_req.addr] <= file_req.wdata;
	end
endmodule : bsd_mem_model

// File: test/bsd_core_tb.sv
// self-checking bench for the decode core against a cycle model
`timescale 1ns/100ps
`include "bsd_defs.svh"

module bsd_core_tb;
	import bsd_pkg::*;
	logic clock, rst_n, ext_set_en, ew, hit;
	logic [20:0] prog_addr, m_pc, np;
	logic [15:0] prog_data, m_ir, fw, wd;
	logic [11:0] index_base, ad;
	logic [7:0] file_rd_data, w_reg, m_w, v, r, f;
	logic [7:0] mfile [4096];
	logic [4:0] m_st;
	logic [3:0] bank_select_register;
	logic [1:0] phase;
	bsd_file_req_t file_req;
	bsd_status_t status;
	int m_nops, ncyc, cyc, err_total, checks_done, i;
	int unsigned rv;

	bsd_core bsd_core_inst (.clock(clock), .rst_n(rst_n), .prog_addr(prog_addr), .prog_data(prog_data),
		.file_req(file_req), .file_rd_data(file_rd_data), .bank_select_register(bank_select_register),
		.index_base(index_base), .ext_set_en(ext_set_en), .w_reg(w_reg), .status(status), .phase(phase));
	bsd_mem_model bsd_mem_model_inst (.clock(clock), .prog_addr(prog_addr), .prog_data(prog_data),
		.file_req(file_req), .file_rd_data(file_rd_data));

	initial begin
		clock = 1'b0;
		forever #2.5 clock = ~clock;
	end

	task automatic chk(input string nm, input logic [20:0] exp, input logic [20:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("BAD %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask : chk

	task automatic finish_test;
		$display("comparisons %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test

	function automatic logic two_word(input logic [15:0] w);
		return w[15:12] == `BSD_TW_MOVE || w[15:9] == `BSD_TW_CALL || w[15:8] == `BSD_TW_LOADFSR
			|| w[15:8] == `BSD_OP_JUMP_FIRST;
	endfunction : two_word

	// ==========================================================
	// cycle model, stepped in the last phase when all results stand
	always @(negedge clock) begin
		if (rst_n && phase === `BSD_Q4) begin
			chk("prog_addr", m_pc, prog_addr);
			fw = bsd_mem_model_inst.prog[m_pc[8:1]];
			np = m_pc + `BSD_PC_STEP;
			ew = 1'b0;
			if (m_nops > 0) begin
				m_nops--;
			end else begin
				f = m_ir[7:0];
				ad = m_ir[8] ? {bank_select_register, f}
					: (ext_set_en && f <= `BSD_IDX_LIMIT) ? index_base + 12'(f)
					: (f < `BSD_ACC_SPLIT) ? {`BSD_ACC_LO_BANK, f} : {`BSD_ACC_HI_BANK, f};
				v = mfile[ad];
				if (m_ir[15:12] == `BSD_OP_SKIP_CLR || m_ir[15:12] == `BSD_OP_SKIP_SET) begin
					hit = (m_ir[15:12] == `BSD_OP_SKIP_SET) ? v[m_ir[11:9]] : !v[m_ir[11:9]];
					chk("test addr", 21'(ad), 21'(file_req.addr));
					if (hit)
						m_nops = two_word(fw) ? 2 : 1;
				end else if (m_ir[15:10] == `BSD_OP_INC) begin
					r = v + `BSD_ONE;
					m_st = {r[7], v == `BSD_POS_MAX, r == 8'h00, v[3:0] == `BSD_NIB_MAX, v == `BSD_BYTE_MAX};
					if (m_ir[`BSD_DEST_BIT]) begin
						ew = 1'b1;
						mfile[ad] = r;
					end else begin
						m_w = r;
						chk("read addr", 21'(ad), 21'(file_req.addr));
					end
				end else if (m_ir[15:8] == `BSD_OP_JUMP_FIRST) begin
					np = {fw[11:0], m_ir[7:0], 1'b0};
					m_nops = 1;
				end
			end
			chk("w_reg", 21'(m_w), 21'(w_reg));
			chk("status", 21'(m_st), 21'(status));
			chk("we", 21'(ew), 21'(file_req.we));
			if (ew) begin
				chk("addr", 21'(ad), 21'(file_req.addr));
				chk("wdata", 21'(r), 21'(file_req.wdata));
			end
			m_pc = np;
			m_ir = fw;
			ncyc++;
			rv = $urandom;
			bank_select_register = rv[3:0];
			index_base = rv[15:4];
			ext_set_en = rv[16];
		end
	end

	// hang guard, well above the 3000 cycle run
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test;
		end
	end

	initial begin
		rst_n = 1'b0;
		bank_select_register = 4'h0;
		index_base = 12'h000;
		ext_set_en = 1'b0;
		m_pc = `BSD_PC_RESET;
		m_ir = `BSD_NOP_WORD;
		m_w = `BSD_W_RESET;
		m_st = 5'h00;
		void'($urandom(32'h67f5_4a81));
		for (i = 0; i < 4096; i++) begin
			mfile[i] = 8'($urandom);
			bsd_mem_model_inst.data_mem[i] = mfile[i];
		end
		// random program mixing every handled opcode and two-word prefixes
		i = 0;
		while (i < 256) begin
			rv = $urandom;
			case (rv[31:29])
				3'd0: wd = {`BSD_OP_SKIP_CLR, rv[11:0]};
				3'd1: wd = {`BSD_OP_SKIP_SET, rv[11:0]};
				3'd2, 3'd3: wd = {`BSD_OP_INC, rv[9:0]};
				3'd4: wd = {`BSD_OP_JUMP_FIRST, rv[7:0]};
				3'd5: wd = {`BSD_TW_MOVE, rv[11:0]};
				3'd6: wd = {`BSD_TW_CALL, rv[8:0]};
				default: wd = {`BSD_TW_LOADFSR, rv[7:0]};
			endcase
			bsd_mem_model_inst.prog[i] = wd;
			if (rv[31:29] > 3)
				bsd_mem_model_inst.prog[(i + 1) % 256] = {`BSD_OP_JUMP_SECOND, rv[23:12]};
			i += (rv[31:29] > 3) ? 2 : 1;
		end
		repeat (3) @(negedge clock);
		chk("reset pc", `BSD_PC_RESET, prog_addr);
		chk("reset phase", 21'(`BSD_Q1), 21'(phase));
		rst_n = 1'b1;
		while (ncyc < 3000)
			@(negedge clock);
		finish_test;
	end
endmodule : bsd_core_tb
